//--- hdl/dim_counter.sv
/*
 * dim_counter: up counter with synchronous clear and increment.
 * Assumes the user bounds the count; clear wins over increment.
 */
`timescale 1ns/1ps
module dim_counter #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   // control
   input  wire logic         clr,
   input  wire logic         inc,
   output logic      [W-1:0] cnt
);
   logic [W-1:0] cnt_next;

   // clear first so a restart never carries a stale count
   always_comb begin
      cnt_next = cnt;
      if (clr) begin
         cnt_next = '0;
      end else if (inc) begin
         cnt_next = cnt + W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
      end else begin
         cnt <= cnt_next;
      end
   end
endmodule : dim_counter

//--- hdl/dim_params.svh
/*
 * dim_params.svh: offsets, field positions, reset values and timing counts
 * of the dual-input range inhibit monitor.
 * Assumes a 100 MHz system clock and an AXI4-Lite bus with 32-bit data.
 */
`ifndef DIM_PARAMS_SVH
`define DIM_PARAMS_SVH

// register byte offsets
`define DIM_OFS_CTRL      8'h00
`define DIM_OFS_THRESH    8'h04
`define DIM_OFS_STATUS    8'h08
`define DIM_OFS_HIST      8'h0C
`define DIM_OFS_IRQ_STAT  8'h10
`define DIM_OFS_IRQ_MASK  8'h14
`define DIM_OFS_WARM      8'h18

// field positions
`define DIM_CTRL_CHECK_EN 0
`define DIM_CTRL_SVC_EN   1
`define DIM_HIST_STORED   0
`define DIM_IRQ_FAULT     0
`define DIM_IRQ_AUTOCLR   1

// reset values
`define DIM_RST_CTRL      2'h1
`define DIM_RST_THRESH    16'h00C8
`define DIM_RST_MASK      2'h0

// timing: clock period, evaluation tick, mismatch limit and warm-up clear count
`define DIM_CLK_NS        10
`define DIM_TICK_NS       1000000
`define DIM_TICK_CYCLES   (`DIM_TICK_NS / `DIM_CLK_NS)
`define DIM_MISMATCH_S    120
`define DIM_MISMATCH_MS   (`DIM_MISMATCH_S * 1000)
`define DIM_WARMUP_CLEAR  40

// axi responses
`define DIM_RESP_OKAY     2'h0
`define DIM_RESP_SLVERR   2'h2

`endif

//--- hdl/dim_pkg.sv
/*
 * dim_pkg: types of the dual-input range inhibit monitor.
 * Assumes dim_params.svh is compiled alongside for the numeric constants.
 */
package dim_pkg;

   // mismatch supervision states
   typedef enum logic [1:0] {
      FS_MATCH  = 2'b00,
      FS_TIMING = 2'b01,
      FS_FAULT  = 2'b10
   } dim_fault_state_t;

   // software control bits
   typedef struct packed {
      logic svc_en;
      logic check_en;
   } dim_ctrl_t;

   // live input and block state
   typedef struct packed {
      logic inhibit;
      logic hist;
      logic fault;
      logic sense_on;
      logic select_on;
   } dim_status_t;

endpackage : dim_pkg

//--- hdl/dim_range_inhibit.sv
/*
 * dim_range_inhibit: dual-input auxiliary range inhibit monitor with
 * mismatch fault, lamps, fault history and an AXI4-Lite register slave.
 * Assumes output speed and warm-up pulses come from logic on sys_clk;
 * the two switch inputs are raw pins and are synchronised here.
 */
`timescale 1ns/1ps
`include "dim_params.svh"

module dim_range_inhibit #(
   parameter int          TICK_CYCLES = `DIM_TICK_CYCLES,
   parameter int          MISMATCH_MS = `DIM_MISMATCH_MS,
   parameter logic [15:0] FAULT_CODE  = 16'h0A5A  // arbitrary value
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // switch pins, active low
   input  wire logic        selector_return_n,
   input  wire logic        sense_ground_n,
   // vehicle state
   input  wire logic [15:0] output_speed,
   input  wire logic        warmup_done,
   // shift control
   input  wire logic        n2r_request,
   output logic             n2r_grant,
   output logic             shift_block,
   // lamps
   output logic             check_transmission_lamp,
   output logic             service_transmission_lamp,
   // interrupt
   output logic             irq,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam int PW = 17;
   localparam int MW = 17;
   localparam int WW = 6;

   // bus state
   logic [7:0]  awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        aw_full_reg, aw_full_next;
   logic        w_full_reg, w_full_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wr_fire;
   logic [31:0] wmask;

   // core state
   dim_pkg::dim_ctrl_t        ctrl_reg, ctrl_next;
   logic [15:0]               thresh_reg, thresh_next;
   logic [1:0]                irq_st_reg, irq_st_next;
   logic [1:0]                irq_mask_reg, irq_mask_next;
   logic                      hist_reg, hist_next;
   logic                      inhibit_reg, inhibit_next;
   logic                      both_on_reg;
   dim_pkg::dim_fault_state_t fstate_reg, fstate_next;
   dim_pkg::dim_status_t      status;

   // inputs and timers
   logic [1:0]    pins_sync;
   logic          select_on, sense_on, both_on, mismatch, fault_active;
   logic          tick, fault_set, auto_clr, tool_clr, speed_over;
   logic [PW-1:0] pre_cnt;
   logic [MW-1:0] mis_cnt;
   logic [WW-1:0] warm_cnt;

   dim_sync #(.W(2)) u_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .async_in ({sense_ground_n, selector_return_n}),
      .sync_out (pins_sync)
   );

   // a pulled-low pin means the switch is closed
   assign select_on = ~pins_sync[0];
   assign sense_on  = ~pins_sync[1];
   assign both_on   = select_on & sense_on;
   assign mismatch  = select_on ^ sense_on;
   assign fault_active = (fstate_reg == dim_pkg::FS_FAULT);

   // millisecond tick, restarted with each timing run so the limit is exact
   assign tick = (pre_cnt == PW'(TICK_CYCLES - 1));
   dim_counter #(.W(PW)) u_prescale (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clr     (tick | (fstate_reg != dim_pkg::FS_TIMING)),
      .inc     (1'b1),
      .cnt     (pre_cnt)
   );

   // duration of the current disagreement in ticks
   dim_counter #(.W(MW)) u_mismatch (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clr     (~mismatch | ~ctrl_reg.check_en),
      .inc     (tick & (fstate_reg == dim_pkg::FS_TIMING)),
      .cnt     (mis_cnt)
   );

   // warm-up cycles survived while a fault is stored
   assign auto_clr = hist_reg & warmup_done & (warm_cnt == WW'(`DIM_WARMUP_CLEAR - 1))
                     & ~fault_active;
   dim_counter #(.W(WW)) u_warm (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clr     (fault_active | ~hist_reg | auto_clr),
      .inc     (warmup_done),
      .cnt     (warm_cnt)
   );

   // one tick past the limit makes the disagreement strictly longer than it
   assign fault_set = (fstate_reg == dim_pkg::FS_TIMING) & tick & mismatch
                      & ctrl_reg.check_en & (mis_cnt == MW'(MISMATCH_MS));

   // mismatch supervision
   always_comb begin
      fstate_next = fstate_reg;
      unique case (fstate_reg)
         dim_pkg::FS_MATCH: begin
            if (ctrl_reg.check_en && mismatch) begin
               fstate_next = dim_pkg::FS_TIMING;
            end
         end
         dim_pkg::FS_TIMING: begin
            if (!ctrl_reg.check_en || !mismatch) begin
               fstate_next = dim_pkg::FS_MATCH;
            end else if (fault_set) begin
               fstate_next = dim_pkg::FS_FAULT;
            end
         end
         dim_pkg::FS_FAULT: begin
            if (!ctrl_reg.check_en || !mismatch) begin
               fstate_next = dim_pkg::FS_MATCH;
            end
         end
         default: fstate_next = dim_pkg::FS_MATCH;
      endcase
   end

   // range inhibit arms on both inputs turning on, released by off or speed
   assign speed_over = (output_speed > thresh_reg);
   always_comb begin
      inhibit_next = inhibit_reg;
      if (!both_on || speed_over) begin
         inhibit_next = 1'b0;
      end else if (!both_on_reg) begin
         inhibit_next = 1'b1;
      end
   end

   // a fault means the inputs cannot be trusted, so the block is lifted
   assign shift_block = inhibit_reg & ~fault_active;
   assign n2r_grant   = n2r_request & ~shift_block;
   assign check_transmission_lamp   = fault_active;
   assign service_transmission_lamp = fault_active & ctrl_reg.svc_en;
   assign irq = |(irq_st_reg & irq_mask_reg);

   // axi4-lite handshakes; address and data taken in either order
   assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign tool_clr = wr_fire & (awaddr_reg == `DIM_OFS_HIST) & wmask[`DIM_HIST_STORED]
                     & wdata_reg[`DIM_HIST_STORED];
   assign status = '{inhibit: shift_block, hist: hist_reg, fault: fault_active,
                     sense_on: sense_on, select_on: select_on};

   // bus channel state and read mux
   always_comb begin
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      aw_full_next = aw_full_reg;
      w_full_next  = w_full_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_next  = s_axi_awaddr;
         aw_full_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
         w_full_next = 1'b1;
      end
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = `DIM_RESP_OKAY;
         unique case (awaddr_reg)
            `DIM_OFS_CTRL, `DIM_OFS_THRESH, `DIM_OFS_STATUS, `DIM_OFS_HIST,
            `DIM_OFS_IRQ_STAT, `DIM_OFS_IRQ_MASK, `DIM_OFS_WARM: bresp_next = `DIM_RESP_OKAY;
            default: bresp_next = `DIM_RESP_SLVERR;
         endcase
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next  = `DIM_RESP_OKAY;
         rdata_next  = 32'h0000_0000;
         unique case (s_axi_araddr)
            `DIM_OFS_CTRL:     rdata_next = {30'h0000_0000, ctrl_reg};
            `DIM_OFS_THRESH:   rdata_next = {16'h0000, thresh_reg};
            `DIM_OFS_STATUS:   rdata_next = {27'h000_0000, status};
            `DIM_OFS_HIST:     rdata_next = {hist_reg ? FAULT_CODE : 16'h0000, 15'h0000, hist_reg};
            `DIM_OFS_IRQ_STAT: rdata_next = {30'h0000_0000, irq_st_reg};
            `DIM_OFS_IRQ_MASK: rdata_next = {30'h0000_0000, irq_mask_reg};
            `DIM_OFS_WARM:     rdata_next = {26'h000_0000, warm_cnt};
            default:           rresp_next = `DIM_RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // software registers, history and sticky events; hardware set beats clear
   always_comb begin
      ctrl_next     = ctrl_reg;
      thresh_next   = thresh_reg;
      irq_mask_next = irq_mask_reg;
      irq_st_next   = irq_st_reg;
      hist_next     = hist_reg;
      if (wr_fire && awaddr_reg == `DIM_OFS_CTRL && wstrb_reg[0]) begin
         ctrl_next = dim_pkg::dim_ctrl_t'(wdata_reg[1:0]);
      end
      if (wr_fire && awaddr_reg == `DIM_OFS_THRESH) begin
         thresh_next = (thresh_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
      end
      if (wr_fire && awaddr_reg == `DIM_OFS_IRQ_MASK && wstrb_reg[0]) begin
         irq_mask_next = wdata_reg[1:0];
      end
      if (wr_fire && awaddr_reg == `DIM_OFS_IRQ_STAT && wstrb_reg[0]) begin
         irq_st_next = irq_st_reg & ~wdata_reg[1:0];
      end
      if (tool_clr || auto_clr) begin
         hist_next = 1'b0;
      end
      if (fault_set) begin
         hist_next = 1'b1;
         irq_st_next[`DIM_IRQ_FAULT] = 1'b1;
      end
      if (auto_clr) begin
         irq_st_next[`DIM_IRQ_AUTOCLR] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= `DIM_RESP_OKAY;
         rvalid_reg   <= 1'b0;
         rresp_reg    <= `DIM_RESP_OKAY;
         rdata_reg    <= 32'h0000_0000;
         ctrl_reg     <= dim_pkg::dim_ctrl_t'(`DIM_RST_CTRL);
         thresh_reg   <= `DIM_RST_THRESH;
         irq_st_reg   <= 2'h0;
         irq_mask_reg <= `DIM_RST_MASK;
         hist_reg     <= 1'b0;
         inhibit_reg  <= 1'b0;
         both_on_reg  <= 1'b0;
         fstate_reg   <= dim_pkg::FS_MATCH;
      end else begin
         awaddr_reg   <= awaddr_next;
         wdata_reg    <= wdata_next;
         wstrb_reg    <= wstrb_next;
         aw_full_reg  <= aw_full_next;
         w_full_reg   <= w_full_next;
         bvalid_reg   <= bvalid_next;
         bresp_reg    <= bresp_next;
         rvalid_reg   <= rvalid_next;
         rresp_reg    <= rresp_next;
         rdata_reg    <= rdata_next;
         ctrl_reg     <= ctrl_next;
         thresh_reg   <= thresh_next;
         irq_st_reg   <= irq_st_next;
         irq_mask_reg <= irq_mask_next;
         hist_reg     <= hist_next;
         inhibit_reg  <= inhibit_next;
         both_on_reg  <= both_on;
         fstate_reg   <= fstate_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;

   // checks on the block's own behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   AST_PIN_SENSE: assert property ($past(resetn, 2) |-> select_on == !$past(selector_return_n, 2)
                                   && sense_on == !$past(sense_ground_n, 2))
      else $error("selector on state does not follow pin");
   AST_NO_GRANT: assert property (both_on && inhibit_reg && !fault_active |-> !n2r_grant)
      else $error("shift granted while both inputs on");
   AST_RELEASE: assert property (!both_on || speed_over |=> !inhibit_reg)
      else $error("inhibit held after release condition");
   AST_FAULT_TIME: assert property ($rose(fault_active) |-> $past(mis_cnt) == MW'(MISMATCH_MS))
      else $error("fault set before mismatch limit");
   AST_CHECK_OFF: assert property (!ctrl_reg.check_en |=> !fault_active)
      else $error("fault active with check disabled");
   AST_CHECK_LAMP: assert property (check_transmission_lamp == (fstate_reg == dim_pkg::FS_FAULT))
      else $error("check lamp does not follow fault");
   AST_SVC_LAMP: assert property (service_transmission_lamp |-> fault_active && ctrl_reg.svc_en)
      else $error("service lamp on without enabled fault");
   AST_HIST_REC: assert property ($rose(fault_active) |-> hist_reg && irq_st_reg[0])
      else $error("fault not recorded in history");
   AST_LIFT: assert property (fault_active |-> !shift_block && (n2r_grant == n2r_request))
      else $error("shift block held during fault");
   AST_AUTO_CLR: assert property (auto_clr && !fault_set |=> !hist_reg && warm_cnt == 0)
      else $error("history not cleared after warm-up cycles");
   AST_TOOL_CLR: assert property (tool_clr && !fault_set |=> !hist_reg)
      else $error("tool clear ignored");
   AST_RESTART: assert property (!mismatch |=> mis_cnt == 0 && !fault_active)
      else $error("mismatch timer not restarted");
endmodule : dim_range_inhibit

//--- hdl/dim_sync.sv
/*
 * dim_sync: two-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a slow level from a pin; no bus coherency is implied.
 */
`timescale 1ns/1ps
module dim_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage; reset to the released level
   // of an active-low pin, so that no false closure follows reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '1;
         sync_out <= '1;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : dim_sync

//--- sim/dim_range_inhibit_bench.sv
/*
 * dim_range_inhibit_bench: self-checking bench of the range inhibit monitor.
 * Assumes short tick and mismatch counts so that a fault sets in ~30 cycles.
 */
`timescale 1ns/1ps
`include "dim_params.svh"
module dim_range_inhibit_bench;
   localparam logic [15:0] FC = 16'h1B2C; // arbitrary value
   logic        sys_clk, resetn, sel_c, sns_c, sel_n, sns_n, warm_go, warm_p, warm_busy;
   logic [5:0]  warm_n;
   logic [15:0] output_speed;
   logic        n2r_request, n2r_grant, shift_block, lamp, svc_lamp, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   int          fails, samples_checked;

   dim_range_inhibit #(.TICK_CYCLES(4), .MISMATCH_MS(5), .FAULT_CODE(FC)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .selector_return_n(sel_n),
      .sense_ground_n(sns_n), .output_speed(output_speed), .warmup_done(warm_p),
      .n2r_request(n2r_request), .n2r_grant(n2r_grant), .shift_block(shift_block),
      .check_transmission_lamp(lamp), .service_transmission_lamp(svc_lamp), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   dim_vehicle_model u_veh (
      .sys_clk(sys_clk), .resetn(resetn), .sel_closed(sel_c), .sense_closed(sns_c),
      .warm_n(warm_n), .warm_go(warm_go), .selector_return_n(sel_n),
      .sense_ground_n(sns_n), .warmup_done(warm_p), .warm_busy(warm_busy));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // let n edges pass, then sample mid-cycle where outputs are settled
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : cyc

   // readiness seen at the negedge is what the next rising edge samples
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_ok, w_ok, ta, tw, bv;
      int n;
      @(posedge sys_clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      aw_ok = 0; w_ok = 0; bv = 0; n = 0;
      while (!(aw_ok && w_ok) && n < 100) begin
         @(negedge sys_clk);
         ta = awready && !aw_ok;
         tw = wready && !w_ok;
         @(posedge sys_clk);
         if (ta) begin aw_ok = 1; awvalid <= 1'b0; end
         if (tw) begin w_ok = 1; wvalid <= 1'b0; end
         n++;
      end
      while (!bv && n < 200) begin
         @(negedge sys_clk);
         bv = bvalid;
         if (bv) chk(bresp, er);
         @(posedge sys_clk);
         n++;
      end
      bready <= 1'b0;
      if (!bv) chk(1'b0, 1'b1);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit got;
      int n;
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      got = 0; n = 0;
      while (!got && n < 100) begin
         @(negedge sys_clk);
         if (arready) begin
            @(posedge sys_clk);
            arvalid <= 1'b0;
            @(negedge sys_clk);
         end
         if (rvalid) begin
            got = 1;
            chk(rdata, ed);
            chk(rresp, er);
         end
         @(posedge sys_clk);
         n++;
      end
      rready <= 1'b0;
      if (!got) chk(1'b0, 1'b1);
   endtask : rd_chk

   task automatic sw(input logic s, input logic g);
      @(posedge sys_clk);
      sel_c <= s; sns_c <= g;
   endtask : sw

   // bounded wait for the fault lamp
   task automatic wait_lamp(input int lim);
      int n;
      n = 0;
      while (lamp !== 1'b1 && n < lim) begin
         cyc(0);
         n++;
      end
   endtask : wait_lamp

   task automatic warm(input logic [5:0] n);
      int k;
      @(posedge sys_clk);
      warm_n <= n; warm_go <= 1'b1;
      @(posedge sys_clk);
      warm_go <= 1'b0;
      k = 0;
      do begin cyc(0); k++; end while (warm_busy && k < 200);
   endtask : warm

   // main sequence
   initial begin
      resetn = 1'b0; sel_c = 1'b0; sns_c = 1'b0; warm_n = 6'h00; warm_go = 1'b0;
      output_speed = 16'h0000; n2r_request = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'hF; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; fails = 0; samples_checked = 0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      cyc(4);
      rd_chk(`DIM_OFS_CTRL, 32'h1, `DIM_RESP_OKAY);
      rd_chk(`DIM_OFS_THRESH, 32'hC8, `DIM_RESP_OKAY);
      rd_chk(`DIM_OFS_IRQ_MASK, 32'h0, `DIM_RESP_OKAY);
      rd_chk(8'h1C, 32'h0, `DIM_RESP_SLVERR);
      wr(8'h1C, 32'hFFFF_FFFF, `DIM_RESP_SLVERR);
      $display("test registers done");
      sw(1'b1, 1'b1); n2r_request <= 1'b1; cyc(8);
      chk(shift_block, 1'b1);
      chk(n2r_grant, 1'b0);
      rd_chk(`DIM_OFS_STATUS, 32'h13, `DIM_RESP_OKAY);
      output_speed <= 16'h00C8; cyc(8);
      chk(shift_block, 1'b1);
      output_speed <= 16'h00C9; cyc(8);
      chk(shift_block, 1'b0);
      output_speed <= 16'h0000; cyc(8);
      chk(shift_block, 1'b0);
      sw(1'b0, 1'b0); cyc(8); sw(1'b1, 1'b1); cyc(8);
      chk(shift_block, 1'b1);
      sw(1'b0, 1'b0); cyc(8);
      chk(n2r_grant, 1'b1);
      $display("test inhibit done");
      wr(`DIM_OFS_IRQ_MASK, 32'h3, `DIM_RESP_OKAY);
      sw(1'b1, 1'b0); cyc(16);
      chk(lamp, 1'b0);
      sw(1'b1, 1'b1); cyc(8); sw(1'b0, 1'b1); cyc(16);
      chk(lamp, 1'b0);
      wait_lamp(20);
      chk(lamp, 1'b1);
      chk(svc_lamp, 1'b0);
      chk(irq, 1'b1);
      chk(n2r_grant, 1'b1);
      rd_chk(`DIM_OFS_HIST, {FC, 16'h0001}, `DIM_RESP_OKAY);
      rd_chk(`DIM_OFS_STATUS, 32'h0E, `DIM_RESP_OKAY);
      wr(`DIM_OFS_CTRL, 32'h3, `DIM_RESP_OKAY); cyc(0);
      chk(svc_lamp, 1'b1);
      wr(`DIM_OFS_IRQ_STAT, 32'h1, `DIM_RESP_OKAY); cyc(1);
      chk(irq, 1'b0);
      sw(1'b0, 1'b0); cyc(8);
      chk(lamp, 1'b0);
      chk(svc_lamp, 1'b0);
      $display("test fault done");
      warm(6'd39);
      rd_chk(`DIM_OFS_WARM, 32'd39, `DIM_RESP_OKAY);
      rd_chk(`DIM_OFS_HIST, {FC, 16'h0001}, `DIM_RESP_OKAY);
      warm(6'd1); cyc(1);
      rd_chk(`DIM_OFS_HIST, 32'h0, `DIM_RESP_OKAY);
      chk(irq, 1'b1);
      wr(`DIM_OFS_IRQ_STAT, 32'h2, `DIM_RESP_OKAY); cyc(1);
      chk(irq, 1'b0);
      $display("test warm-up done");
      sw(1'b0, 1'b1); cyc(16); wait_lamp(20);
      chk(lamp, 1'b1);
      sw(1'b0, 1'b0); cyc(8);
      wr(`DIM_OFS_HIST, 32'h1, `DIM_RESP_OKAY);
      rd_chk(`DIM_OFS_HIST, 32'h0, `DIM_RESP_OKAY);
      wr(`DIM_OFS_IRQ_STAT, 32'h3, `DIM_RESP_OKAY);
      $display("test tool clear done");
      wr(`DIM_OFS_CTRL, 32'h0, `DIM_RESP_OKAY);
      sw(1'b1, 1'b0); cyc(60);
      chk(lamp, 1'b0);
      rd_chk(`DIM_OFS_HIST, 32'h0, `DIM_RESP_OKAY);
      sw(1'b0, 1'b0);
      $display("test check disable done");
      close_out();
   end

   // watchdog: the whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      close_out();
   end
endmodule : dim_range_inhibit_bench

//--- sim/dim_vehicle_model.sv
/*
 * dim_vehicle_model: the far side of the monitor, meaning the two vehicle
 * switches and the warm-up cycle source.
 * Assumes sys_clk is the monitor's clock and the bench drives its controls.
 */
`timescale 1ns/1ps
module dim_vehicle_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // switch closures and warm-up burst request
   input  wire logic       sel_closed,
   input  wire logic       sense_closed,
   input  wire logic [5:0] warm_n,
   input  wire logic       warm_go,
   // pins towards the monitor, and the burst busy flag to the bench
   output logic            selector_return_n,
   output logic            sense_ground_n,
   output logic            warmup_done,
   output logic            warm_busy
);
   logic [5:0] left;

   // a closed switch pulls its pin low; open pins float up to high
   assign selector_return_n = ~sel_closed;
   assign sense_ground_n    = ~sense_closed;

   // one-cycle pulses with a gap, so that no two warm-up cycles merge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         left        <= 6'h00;
         warmup_done <= 1'b0;
      end else if (warm_go) begin
         left        <= warm_n;
         warmup_done <= 1'b0;
      end else if (left != 6'h00 && !warmup_done) begin
         left        <= left - 6'h01;
         warmup_done <= 1'b1;
      end else begin
         warmup_done <= 1'b0;
      end
   end

   assign warm_busy = (left != 6'h00) || warmup_done;
endmodule : dim_vehicle_model
